// ---- shared/wta_pkg.sv ----
`default_nettype none
// ==========================================
// Shared constants for the word datapath
// ==========================================
package wta_pkg;

  // Word and address widths
  localparam int WORD_W = 48;
  localparam int ADDR_W = 15;
  localparam int OP_W   = 5;

  // Zero word used by clears
  localparam logic [WORD_W-1:0] WORD_ZERO = 48'h0;

  // Operation codes, one-word transfers
  localparam logic [OP_W-1:0] OP_MEM_TO_ACCUM       = 5'h00;
  localparam logic [OP_W-1:0] OP_MEM_TO_DATA_REG    = 5'h01;
  localparam logic [OP_W-1:0] OP_MEM_TO_AUX_REG     = 5'h02;
  localparam logic [OP_W-1:0] OP_ACCUM_TO_MEM       = 5'h03;
  localparam logic [OP_W-1:0] OP_ACCUM_TO_DATA_REG  = 5'h04;
  localparam logic [OP_W-1:0] OP_ACCUM_TO_AUX_REG   = 5'h05;
  localparam logic [OP_W-1:0] OP_AUX_REG_TO_MEM     = 5'h06;
  localparam logic [OP_W-1:0] OP_AUX_REG_TO_ACCUM   = 5'h07;
  localparam logic [OP_W-1:0] OP_AUX_REG_TO_DATA_REG = 5'h08;
  localparam logic [OP_W-1:0] OP_DATA_REG_TO_MEM    = 5'h09;
  localparam logic [OP_W-1:0] OP_DATA_REG_TO_ACCUM  = 5'h0a;
  localparam logic [OP_W-1:0] OP_DATA_REG_TO_AUX_REG = 5'h0b;
  // Clears
  localparam logic [OP_W-1:0] OP_ZERO_MEMORY_WORD   = 5'h0c;
  localparam logic [OP_W-1:0] OP_ZERO_ACCUM         = 5'h0d;
  localparam logic [OP_W-1:0] OP_ZERO_DATA_REG      = 5'h0e;
  localparam logic [OP_W-1:0] OP_ZERO_AUX_REG       = 5'h0f;
  // Fixed-point add and subtract
  localparam logic [OP_W-1:0] OP_SUM_WITH_DATA_REG  = 5'h10;
  localparam logic [OP_W-1:0] OP_MINUS_DATA_REG     = 5'h11;
  localparam logic [OP_W-1:0] OP_SUM_WITH_MEMORY_WORD = 5'h12;
  localparam logic [OP_W-1:0] OP_MINUS_MEMORY_WORD  = 5'h13;
  localparam logic [OP_W-1:0] OP_SUM_WITH_AUX_REG   = 5'h14;
  localparam logic [OP_W-1:0] OP_MINUS_AUX_REG      = 5'h15;

  // Storage elements a word can come from or go to
  typedef enum logic [2:0] {
    LOC_NONE,
    LOC_MEM,
    LOC_ACC,
    LOC_AUX,
    LOC_DAT
  } wta_loc_t;

endpackage
`default_nettype wire

// ---- rtl/wta_datapath.sv ----
// Summary of operation
// - Transfer decodes as one source, one destination
// - No same-element or memory-to-memory transfer
// - Copy word, source kept, destination overwritten
// - Indirect moves pass through data register
// - Data register moves happen in one step
// - Address used only for memory accesses
// - Clears set target to zero
// - Clears leave data register alone unless it is the target
// - Accumulator plus/minus data register into accumulator
// - Memory/aux operand loaded into data register first
// - Accumulator used as is, not loaded
// - Absolute and store options independently selectable
// - Absolute option uses operand magnitude
// - Store writes only the operand's address
// - Result passes data register before memory
// - Clear variants zero accumulator first
// - Data register arithmetic takes no options
`timescale 1ns/1ns
`default_nettype none

module wta_datapath
  import wta_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_op_valid,
  input  wire logic [OP_W-1:0]   i_op,
  input  wire logic              i_abs,
  input  wire logic              i_store,
  input  wire logic              i_clear_first,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic                   o_op_ready,
  output logic                   o_done,
  output logic                   o_illegal,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic [WORD_W-1:0]      o_mem_wdata,
  input  wire logic [WORD_W-1:0] i_mem_rdata,
  output logic [WORD_W-1:0]      o_accum,
  output logic [WORD_W-1:0]      o_aux_reg,
  output logic [WORD_W-1:0]      o_data_reg
);

  // ==========================================
  // Sequencer states
  // ==========================================
  typedef enum logic [3:0] {
    ST_IDLE,    // Waiting for an operation
    ST_RD,      // Memory read strobe out
    ST_LOAD_D,  // Source word into data reg
    ST_MOVE,    // Data reg to destination
    ST_CLEAR,   // Zero the target
    ST_ARITH,   // Add or subtract into accum
    ST_STORE_D, // Result into data reg
    ST_STORE_M  // Data reg into memory
  } wta_state_t;

  // ==========================================
  // State and registers
  // ==========================================
  wta_state_t          state_r, state_nxt;   // Sequencer
  logic [OP_W-1:0]     op_r, op_nxt;         // Latched op
  logic                abs_r, abs_nxt;       // Magnitude option
  logic                store_r, store_nxt;   // Store option
  logic                clr_r, clr_nxt;       // Clear-first
  logic [ADDR_W-1:0]   addr_r, addr_nxt;     // Address field
  logic [WORD_W-1:0]   accum_r, accum_nxt;   // Accumulator
  logic [WORD_W-1:0]   aux_r, aux_nxt;       // Auxiliary reg
  logic [WORD_W-1:0]   data_r, data_nxt;     // Data register
  logic                rd_r, rd_nxt;         // Read strobe
  logic                wr_r, wr_nxt;         // Write strobe
  logic [ADDR_W-1:0]   maddr_r, maddr_nxt;   // Memory address
  logic [WORD_W-1:0]   wdata_r, wdata_nxt;   // Write data
  logic                done_r, done_nxt;     // Done pulse
  logic                ill_r, ill_nxt;       // Bad code pulse

  // Decoded fields of the latched operation
  wta_loc_t            src_loc;              // Source element
  wta_loc_t            dst_loc;              // Destination
  logic                is_arith;             // Add/sub class
  logic                is_sub;               // Subtract
  // Arithmetic helpers
  logic [WORD_W-1:0]   opnd;                 // Chosen operand
  logic [WORD_W-1:0]   base;                 // Augend/minuend
  logic [WORD_W-1:0]   result;               // Sum/difference

  // ==========================================
  // Operation decode
  // ==========================================
  // Source of each transfer, or operand site
  function automatic wta_loc_t src_of(
    input logic [OP_W-1:0] op
  );
    case (op)
      OP_MEM_TO_ACCUM, OP_MEM_TO_DATA_REG, OP_MEM_TO_AUX_REG,
      OP_SUM_WITH_MEMORY_WORD, OP_MINUS_MEMORY_WORD: src_of = LOC_MEM;
      OP_ACCUM_TO_MEM, OP_ACCUM_TO_DATA_REG,
      OP_ACCUM_TO_AUX_REG:     src_of = LOC_ACC;
      OP_AUX_REG_TO_MEM, OP_AUX_REG_TO_ACCUM, OP_AUX_REG_TO_DATA_REG,
      OP_SUM_WITH_AUX_REG, OP_MINUS_AUX_REG: src_of = LOC_AUX;
      OP_DATA_REG_TO_MEM, OP_DATA_REG_TO_ACCUM, OP_DATA_REG_TO_AUX_REG,
      OP_SUM_WITH_DATA_REG, OP_MINUS_DATA_REG: src_of = LOC_DAT;
      default:                 src_of = LOC_NONE;
    endcase
  endfunction

  // Destination of each transfer or clear target
  function automatic wta_loc_t dst_of(
    input logic [OP_W-1:0] op
  );
    case (op)
      OP_ACCUM_TO_MEM, OP_AUX_REG_TO_MEM,
      OP_DATA_REG_TO_MEM, OP_ZERO_MEMORY_WORD: dst_of = LOC_MEM;
      OP_MEM_TO_ACCUM, OP_AUX_REG_TO_ACCUM,
      OP_DATA_REG_TO_ACCUM, OP_ZERO_ACCUM:     dst_of = LOC_ACC;
      OP_MEM_TO_AUX_REG, OP_ACCUM_TO_AUX_REG,
      OP_DATA_REG_TO_AUX_REG, OP_ZERO_AUX_REG: dst_of = LOC_AUX;
      OP_MEM_TO_DATA_REG, OP_ACCUM_TO_DATA_REG,
      OP_AUX_REG_TO_DATA_REG, OP_ZERO_DATA_REG: dst_of = LOC_DAT;
      default:                 dst_of = LOC_NONE;
    endcase
  endfunction

  // Class flags from the latched code
  always_comb begin
    src_loc  = src_of(op_r);
    dst_loc  = dst_of(op_r);
    is_arith = (op_r >= OP_SUM_WITH_DATA_REG) && (op_r <= OP_MINUS_AUX_REG);
    is_sub   = op_r[0];
  end

  // ==========================================
  // Adder: accum plus or minus data reg
  // ==========================================
  always_comb begin
    opnd = data_r;
    if (abs_r && data_r[WORD_W-1]) begin
      opnd = -data_r;
    end
    base = clr_r ? WORD_ZERO : accum_r;
    if (is_sub) begin
      result = base - opnd;
    end else begin
      result = base + opnd;
    end
  end

  // ==========================================
  // Next-state logic
  // ==========================================
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    abs_nxt   = abs_r;
    store_nxt = store_r;
    clr_nxt   = clr_r;
    addr_nxt  = addr_r;
    accum_nxt = accum_r;
    aux_nxt   = aux_r;
    data_nxt  = data_r;
    rd_nxt    = 1'b0;
    wr_nxt    = 1'b0;
    maddr_nxt = maddr_r;
    wdata_nxt = wdata_r;
    done_nxt  = 1'b0;
    ill_nxt   = 1'b0;
    case (state_r)
      // Accept and route a new operation
      ST_IDLE: begin
        if (i_op_valid) begin
          op_nxt   = i_op;
          addr_nxt = i_addr;
          // Options only for memory/aux operands
          if (src_of(i_op) != LOC_DAT) begin
            abs_nxt   = i_abs;
            store_nxt = i_store;
            clr_nxt   = i_clear_first;
          end else begin
            abs_nxt   = 1'b0;
            store_nxt = 1'b0;
            clr_nxt   = 1'b0;
          end
          if (i_op > OP_MINUS_AUX_REG) begin
            ill_nxt = 1'b1;
          end else if (i_op >= OP_ZERO_MEMORY_WORD &&
                       i_op <= OP_ZERO_AUX_REG) begin
            state_nxt = ST_CLEAR;
          end else if (src_of(i_op) == LOC_MEM) begin
            rd_nxt    = 1'b1;
            maddr_nxt = i_addr;
            state_nxt = ST_RD;
          end else if (src_of(i_op) == LOC_DAT) begin
            // Arithmetic or move straight from D
            state_nxt = (i_op >= OP_SUM_WITH_DATA_REG) ?
                        ST_ARITH : ST_MOVE;
          end else begin
            state_nxt = ST_LOAD_D;
          end
        end
      end
      // Read strobe is out; data follows
      ST_RD: begin
        state_nxt = ST_LOAD_D;
      end
      // Source word into the data register
      ST_LOAD_D: begin
        if (src_loc == LOC_MEM) begin
          data_nxt = i_mem_rdata;
        end else if (src_loc == LOC_ACC) begin
          data_nxt = accum_r;
        end else begin
          data_nxt = aux_r;
        end
        if (is_arith) begin
          state_nxt = ST_ARITH;
        end else if (dst_loc == LOC_DAT) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end else begin
          state_nxt = ST_MOVE;
        end
      end
      // Data register into destination
      ST_MOVE: begin
        if (dst_loc == LOC_ACC) begin
          accum_nxt = data_r;
        end else if (dst_loc == LOC_AUX) begin
          aux_nxt = data_r;
        end else begin
          wr_nxt    = 1'b1;
          maddr_nxt = addr_r;
          wdata_nxt = data_r;
        end
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end
      // Zero the target; D kept unless target
      ST_CLEAR: begin
        if (dst_loc == LOC_MEM) begin
          wr_nxt    = 1'b1;
          maddr_nxt = addr_r;
          wdata_nxt = WORD_ZERO;
        end else if (dst_loc == LOC_ACC) begin
          accum_nxt = WORD_ZERO;
        end else if (dst_loc == LOC_AUX) begin
          aux_nxt = WORD_ZERO;
        end else begin
          data_nxt = WORD_ZERO;
        end
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end
      // Result into accumulator
      ST_ARITH: begin
        accum_nxt = result;
        if (store_r) begin
          state_nxt = ST_STORE_D;
        end else begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      // Result copied into data register
      ST_STORE_D: begin
        data_nxt  = accum_r;
        state_nxt = ST_STORE_M;
      end
      // Data register written back to operand address
      ST_STORE_M: begin
        wr_nxt    = 1'b1;
        maddr_nxt = addr_r;
        wdata_nxt = data_r;
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // Registers
  // ==========================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      op_r    <= OP_MEM_TO_ACCUM;
      abs_r   <= 1'b0;
      store_r <= 1'b0;
      clr_r   <= 1'b0;
      addr_r  <= '0;
      accum_r <= WORD_ZERO;
      aux_r   <= WORD_ZERO;
      data_r  <= WORD_ZERO;
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      maddr_r <= '0;
      wdata_r <= WORD_ZERO;
      done_r  <= 1'b0;
      ill_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      abs_r   <= abs_nxt;
      store_r <= store_nxt;
      clr_r   <= clr_nxt;
      addr_r  <= addr_nxt;
      accum_r <= accum_nxt;
      aux_r   <= aux_nxt;
      data_r  <= data_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      maddr_r <= maddr_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
      ill_r   <= ill_nxt;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign o_op_ready  = (state_r == ST_IDLE);     // Handshake
  assign o_done      = done_r;
  assign o_illegal   = ill_r;
  assign o_mem_rd    = rd_r;
  assign o_mem_wr    = wr_r;
  assign o_mem_addr  = maddr_r;
  assign o_mem_wdata = wdata_r;
  assign o_accum     = accum_r;
  assign o_aux_reg   = aux_r;
  assign o_data_reg  = data_r;

endmodule
`default_nettype wire

// ---- verif/wta_datapath_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module wta_datapath_checker
  import wta_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_op_valid,
  input wire logic [OP_W-1:0]   i_op,
  input wire logic              i_abs,
  input wire logic              i_store,
  input wire logic              i_clear_first,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              o_op_ready,
  input wire logic              o_done,
  input wire logic              o_illegal,
  input wire logic              o_mem_rd,
  input wire logic              o_mem_wr,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [WORD_W-1:0] o_mem_wdata,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  input wire logic [WORD_W-1:0] o_accum,
  input wire logic [WORD_W-1:0] o_aux_reg,
  input wire logic [WORD_W-1:0] o_data_reg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========
  // Steps
  sequence s_take(logic [OP_W-1:0] c);
    i_op_valid && o_op_ready && i_op == c;
  endsequence
  sequence s_read;
    o_mem_rd && o_mem_addr == $past(i_addr);
  endsequence
  // ==========
  // Checks
  illegal_code_a: assert property (i_op_valid && o_op_ready &&
    i_op > 5'h15 |=> o_illegal && $stable(o_accum) && $stable(o_data_reg))
    else $error("illegal code not refused");
  busy_after_take_a: assert property (i_op_valid && o_op_ready &&
    i_op <= 5'h15 |=> !o_op_ready) else $error("ready after take");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  zero_accum_a: assert property (s_take(OP_ZERO_ACCUM) |-> ##2 o_done
    ##1 o_accum == WORD_ZERO && o_data_reg == $past(o_data_reg, 3))
    else $error("accumulator clear wrong");
  zero_mem_a: assert property (s_take(OP_ZERO_MEMORY_WORD) |->
    ##2 o_done && o_mem_wr && o_mem_wdata == WORD_ZERO &&
    o_mem_addr == $past(i_addr, 2)) else $error("memory clear wrong");
  mem_to_acc_a: assert property (s_take(OP_MEM_TO_ACCUM) |->
    ##1 s_read ##3 o_done && o_accum == o_data_reg)
    else $error("memory to accumulator wrong");
  dat_to_acc_a: assert property (s_take(OP_DATA_REG_TO_ACCUM) |->
    ##2 o_done && o_accum == $past(o_data_reg, 2))
    else $error("data to accumulator wrong");
  acc_to_aux_a: assert property (s_take(OP_ACCUM_TO_AUX_REG) |->
    ##3 o_done && o_aux_reg == $past(o_accum, 3) &&
    o_data_reg == o_aux_reg && o_accum == $past(o_accum, 3))
    else $error("accumulator to aux wrong");
  add_dat_a: assert property (s_take(OP_SUM_WITH_DATA_REG) |->
    ##2 o_done && o_accum == $past(o_accum, 2) + $past(o_data_reg, 2))
    else $error("add data wrong");
  sub_dat_a: assert property (s_take(OP_MINUS_DATA_REG) |->
    ##2 o_done && o_accum == $past(o_accum, 2) - $past(o_data_reg, 2))
    else $error("subtract data wrong");
endmodule
bind wta_datapath wta_datapath_checker wta_datapath_checker_i (.*);
`default_nettype wire

// ---- verif/wta_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Core memory, 16 words, one-cycle read
module wta_mem_model
  import wta_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [WORD_W-1:0] i_wdata,
  output logic      [WORD_W-1:0] o_rdata
);
  logic [WORD_W-1:0] mem [16]; // Storage
  initial o_rdata = 48'h0;
  // Idle data line toggles so stale reads show
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr[3:0]] <= i_wdata;
    if (i_rd) o_rdata <= mem[i_addr[3:0]];
    else o_rdata <= ~o_rdata;
  end
endmodule
`default_nettype wire

// ---- verif/wta_datapath_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module wta_datapath_test;
  import wta_pkg::*;
  logic              clk = 0;
  logic              rst_n = 0;
  logic              vld = 0;
  logic [OP_W-1:0]   op = 5'h0;
  logic [2:0]        f = 3'h0; // Clear-first, store, magnitude
  logic [ADDR_W-1:0] ad = 15'h0;
  logic              rdy, dn, il, rd, wr, got_il;
  logic [ADDR_W-1:0] ma;
  logic [WORD_W-1:0] wd, rdt, acc, aux, dat, e;
  int                n_mismatch = 0;
  int                checked = 0;
  localparam logic [WORD_W-1:0] W1 = 48'h9abc_def0_1234;
  localparam logic [WORD_W-1:0] N3 = 48'hffff_ffff_fffd;
  always #10 clk = ~clk;
  wta_datapath wta_datapath_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_op_valid(vld), .i_op(op), .i_abs(f[0]), .i_store(f[1]),
    .i_clear_first(f[2]), .i_addr(ad), .o_op_ready(rdy), .o_done(dn),
    .o_illegal(il), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(ma),
    .o_mem_wdata(wd), .i_mem_rdata(rdt), .o_accum(acc),
    .o_aux_reg(aux), .o_data_reg(dat));
  wta_mem_model wta_mem_model_i (.i_clk(clk), .i_rd(rd), .i_wr(wr),
    .i_addr(ma), .i_wdata(wd), .o_rdata(rdt));
  // ==========
  // Helpers
  function automatic logic [WORD_W-1:0] mw(input int i);
    return wta_mem_model_i.mem[i];
  endfunction
  task automatic chk(input string nm, input logic [WORD_W-1:0] x,
                     input logic [WORD_W-1:0] g);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  // One request, wait for its answer, let memory land
  task automatic run(input logic [OP_W-1:0] c, input logic [2:0] o,
                     input logic [ADDR_W-1:0] a);
    int n;
    @(posedge clk);
    vld <= 1'b1;
    op <= c;
    f <= o;
    ad <= a;
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    @(negedge clk);
    while (dn !== 1'b1 && il !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    got_il = il;
    chk("answer", 48'h1, {47'h0, dn | il});
    @(negedge clk);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Transfers and clears
  task automatic t_xfer;
    wta_mem_model_i.mem[3] = W1;
    wta_mem_model_i.mem[9] = N3;
    run(OP_MEM_TO_ACCUM, 3'h0, 15'h3);
    chk("dat", W1, dat);
    run(OP_ACCUM_TO_AUX_REG, 3'h7, 15'h0);
    chk("aux", W1, aux);
    run(OP_ZERO_DATA_REG, 3'h0, 15'h0);
    chk("dat", 48'h0, dat);
    run(OP_ACCUM_TO_DATA_REG, 3'h0, 15'h0);
    chk("dat", W1, dat);
    run(OP_ZERO_ACCUM, 3'h0, 15'h0);
    chk("dat", W1, dat);
    run(OP_AUX_REG_TO_MEM, 3'h0, 15'h5);
    chk("m5", W1, mw(5));
    run(OP_ZERO_AUX_REG, 3'h0, 15'h0);
    chk("aux", 48'h0, aux);
    run(OP_DATA_REG_TO_AUX_REG, 3'h0, 15'h0);
    chk("aux", W1, aux);
    run(OP_ZERO_MEMORY_WORD, 3'h0, 15'h3);
    chk("m3", 48'h0, mw(3));
    run(OP_DATA_REG_TO_ACCUM, 3'h0, 15'h0);
    chk("acc", W1, acc);
    run(OP_DATA_REG_TO_MEM, 3'h0, 15'h7);
    chk("m7", W1, mw(7));
    run(OP_MEM_TO_DATA_REG, 3'h0, 15'h9);
    chk("dat", N3, dat);
    chk("acc", W1, acc);
    run(OP_ZERO_ACCUM, 3'h0, 15'h0);
    run(OP_AUX_REG_TO_ACCUM, 3'h0, 15'h0);
    chk("acc", W1, acc);
    chk("dat", W1, dat);
    run(OP_ZERO_DATA_REG, 3'h0, 15'h0);
    run(OP_AUX_REG_TO_DATA_REG, 3'h0, 15'h0);
    chk("dat", W1, dat);
    run(OP_ACCUM_TO_MEM, 3'h0, 15'h9);
    chk("m9", W1, mw(9));
  endtask
  // ==========
  // Every option set on a memory operand
  task automatic t_arith;
    for (int k = 0; k < 16; k++) begin
      wta_mem_model_i.mem[2] = 48'h5;
      wta_mem_model_i.mem[4] = N3;
      run(OP_MEM_TO_ACCUM, 3'h0, 15'h2);
      run(k[3] ? OP_MINUS_MEMORY_WORD : OP_SUM_WITH_MEMORY_WORD,
          k[2:0], 15'h4);
      e = k[0] ? 48'h3 : N3;
      e = k[3] ? (k[2] ? 48'h0 : 48'h5) - e : (k[2] ? 48'h0 : 48'h5) + e;
      chk("acc", e, acc);
      chk("m4", k[1] ? e : N3, mw(4));
      chk("m2", 48'h5, mw(2));
      if (k[1]) chk("dat", e, dat);
    end
  endtask
  // ==========
  // Aux operand then data-register arithmetic
  task automatic t_aux;
    run(OP_MEM_TO_AUX_REG, 3'h0, 15'h4);
    chk("aux", N3, aux);
    run(OP_MEM_TO_ACCUM, 3'h0, 15'h2);
    run(OP_MINUS_AUX_REG, 3'h1, 15'h0);
    chk("acc", 48'h2, acc);
    run(OP_SUM_WITH_AUX_REG, 3'h2, 15'h6);
    chk("m6", 48'hffff_ffff_ffff, mw(6));
    run(OP_SUM_WITH_DATA_REG, 3'h3, 15'h2);
    chk("acc", 48'hffff_ffff_fffe, acc);
    chk("m2", 48'h5, mw(2));
    run(OP_MINUS_DATA_REG, 3'h0, 15'h0);
    chk("acc", 48'hffff_ffff_ffff, acc);
    run(OP_SUM_WITH_AUX_REG, 3'h5, 15'h0);
    chk("acc", 48'h3, acc);
  endtask
  // ==========
  // Codes past the table are refused
  task automatic t_illegal;
    run(5'h16, 3'h0, 15'h0);
    chk("ill", 48'h1, {47'h0, got_il});
    run(5'h1f, 3'h0, 15'h0);
    chk("ill", 48'h1, {47'h0, got_il});
    chk("acc", 48'h3, acc);
  endtask
  // ==========
  // Reset between operations, then work resumes
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk("acc", 48'h0, acc);
    chk("aux", 48'h0, aux);
    chk("dat", 48'h0, dat);
    chk("rdy", 48'h1, {47'h0, rdy});
    @(posedge clk);
    rst_n <= 1'b1;
    run(OP_MEM_TO_ACCUM, 3'h0, 15'h2);
    chk("acc", 48'h5, acc);
  endtask
  // ==========
  // Sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_xfer();
    t_arith();
    t_aux();
    t_illegal();
    t_reset();
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
